// ===== src/ainp_pkg.sv
// Constants for the interrupt enable and pin routing block
package ainp_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_EN_GROUP2  = 8'h18; // Motion engine enables
    localparam logic [7:0] ADDR_ROUTE_A    = 8'h19; // First pin motion routing
    localparam logic [7:0] ADDR_ROUTE_FIFO = 8'h1A; // FIFO and data routing
    localparam logic [7:0] ADDR_PIN_CTRL   = 8'h20; // Pin polarity control

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_EN_GROUP2   = 8'h00; // All engines off
    localparam logic [7:0] RST_ROUTE_A     = 8'h00; // Nothing routed
    localparam logic [7:0] RST_ROUTE_FIFO  = 8'h00; // Nothing routed
    localparam logic [7:0] RST_PIN_CTRL    = 8'h05; // Both pins active high

    // ------------------------------------------------------------
    // Writable bit masks (reserved bits read zero)
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_EN_GROUP2  = 8'h0F; // Bits 7..4 reserved
    localparam logic [7:0] MASK_ROUTE_A    = 8'hFF; // All bits used
    localparam logic [7:0] MASK_ROUTE_FIFO = 8'hE7; // Bits 4 and 3 reserved
    localparam logic [7:0] MASK_PIN_CTRL   = 8'h05; // Only polarity bits held

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MOTION_SEL_BIT  = 3; // 0 slow-motion, 1 no-motion
    localparam int AXIS_Z_BIT      = 2; // Z axis enable
    localparam int AXIS_Y_BIT      = 1; // Y axis enable
    localparam int AXIS_X_BIT      = 0; // X axis enable
    localparam int B_DATA_BIT      = 7; // Data ready to second pin
    localparam int B_WATERMARK_BIT = 6; // Watermark to second pin
    localparam int B_FULL_BIT      = 5; // FIFO full to second pin
    localparam int A_FULL_BIT      = 2; // FIFO full to first pin
    localparam int A_WATERMARK_BIT = 1; // Watermark to first pin
    localparam int A_DATA_BIT      = 0; // Data ready to first pin
    localparam int PIN_A_POL_BIT   = 0; // First pin level select
    localparam int PIN_B_POL_BIT   = 2; // Second pin level select

    // ------------------------------------------------------------
    // Source counts per pin
    // ------------------------------------------------------------
    localparam int PIN_A_SOURCES   = 11; // Eight motion plus three FIFO/data
    localparam int PIN_B_SOURCES   = 3;  // FIFO/data only in this block
endpackage : ainp_pkg

// ===== src/ainp_pin_drive.sv
// Combines routed interrupt sources onto one pin with polarity
`timescale 1ns/1ns
`default_nettype none
module ainp_pin_drive #(
    parameter int N = 1                    // Number of sources
) (
    input  wire logic         sys_clk,     // System clock
    input  wire logic         rst_n,       // Async reset, active low
    input  wire logic         ce,          // Clock enable
    input  wire logic [N-1:0] src_active,  // Active, enabled sources
    input  wire logic [N-1:0] route,       // Per-source routing bits
    input  wire logic         active_high, // 1 active high, 0 active low
    output logic              pin_r        // Registered pin level
);
    // ------------------------------------------------------------
    // Pin level
    // ------------------------------------------------------------
    wire logic any_routed;                 // Any routed source active
    wire logic pin_nxt;                    // Level after polarity

    // (RQ11) any routed source
    assign any_routed = |(src_active & route);
    // (RQ10) apply pin polarity
    assign pin_nxt    = active_high ? any_routed : ~any_routed;

    // Output flop, idle-low matches active-high reset polarity
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_r <= 1'b0;
        end else if (ce) begin
            pin_r <= pin_nxt;
        end
    end
endmodule : ainp_pin_drive
`default_nettype wire

// ===== src/ainp_irq_route.sv
// Interrupt enable group two, pin routing and polarity registers
`timescale 1ns/1ns
`default_nettype none
// Contract
// (RQ1) Group-two enable register, reserved high nibble
// (RQ2) Bit 3 selects slow or no motion
// (RQ3) Bits 2..0 enable z, y, x axes
// (RQ4) Eight-bit first pin motion routing register
// (RQ5) Bits 7..4 route flat, orient, taps
// (RQ6) Bits 3..0 route quiet, slope, high, low
// (RQ7) Shared bits 7..5 route to second pin
// (RQ8) Shared bits 2..0 route to first pin
// (RQ9) Host writes zero to reserved bits
// (RQ10) Pin polarity per level bit, high default
// (RQ11) Pin asserts on enabled routed active source
module ainp_irq_route (
    input  wire logic       sys_clk,          // System clock, 50 MHz
    input  wire logic       rst_n,            // Async reset, active low
    input  wire logic       ce,               // Clock enable, freezes state
    input  wire logic       reg_wr_en,        // Register write strobe
    input  wire logic       reg_rd_en,        // Register read strobe
    input  wire logic [7:0] reg_addr,         // Register offset
    input  wire logic [7:0] reg_wdata,        // Write data
    output logic      [7:0] reg_rdata,        // Registered read data
    input  wire logic       evt_flat,         // Flat interrupt active
    input  wire logic       evt_orientation,  // Orientation interrupt active
    input  wire logic       evt_single_tap,   // Single tap active
    input  wire logic       evt_double_tap,   // Double tap active
    input  wire logic [2:0] evt_quiet_axis,   // Slow/no-motion per axis z,y,x
    input  wire logic       evt_any_motion,   // Slope interrupt active
    input  wire logic       evt_high_accel,   // High-g active
    input  wire logic       evt_low_accel,    // Low-g active
    input  wire logic       evt_data_ready,   // Data ready active
    input  wire logic       evt_watermark,    // FIFO watermark active
    input  wire logic       evt_fifo_full,    // FIFO full active
    output logic            quiet_mode_r,     // 0 slow-motion, 1 no-motion
    output logic      [2:0] quiet_axis_en_r,  // Axis enables z,y,x
    output logic            first_irq_pin,    // First interrupt pin
    output logic            second_irq_pin    // Second interrupt pin
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] en_group2_r;                  // Group-two enables
    logic [7:0] route_a_r;                    // First pin motion routing
    logic [7:0] route_fifo_r;                 // Shared FIFO/data routing
    logic [7:0] pin_ctrl_r;                   // Pin polarity bits
    logic [7:0] reg_rdata_r;                  // Read data holder

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic hit_en2   = reg_addr == ainp_pkg::ADDR_EN_GROUP2;  // Enables
    wire logic hit_rta   = reg_addr == ainp_pkg::ADDR_ROUTE_A;    // Route A
    wire logic hit_rtf   = reg_addr == ainp_pkg::ADDR_ROUTE_FIFO; // Shared
    wire logic hit_ctl   = reg_addr == ainp_pkg::ADDR_PIN_CTRL;   // Polarity
    wire logic wr_en2    = ce && reg_wr_en && hit_en2;            // Write en2
    wire logic wr_rta    = ce && reg_wr_en && hit_rta;            // Write route A
    wire logic wr_rtf    = ce && reg_wr_en && hit_rtf;            // Write shared
    wire logic wr_ctl    = ce && reg_wr_en && hit_ctl;            // Write polarity
    wire logic [7:0] rd_mux;                                      // Read select

    // Read selection, unmapped offsets read zero
    assign rd_mux = hit_en2 ? en_group2_r  :
                    hit_rta ? route_a_r    :
                    hit_rtf ? route_fifo_r :
                    hit_ctl ? pin_ctrl_r   : 8'h00;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // (RQ1) group-two enable storage, reserved dropped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_group2_r <= ainp_pkg::RST_EN_GROUP2;
        end else if (wr_en2) begin
            en_group2_r <= reg_wdata & ainp_pkg::MASK_EN_GROUP2;
        end
    end

    // (RQ4) first pin routing storage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            route_a_r <= ainp_pkg::RST_ROUTE_A;
        end else if (wr_rta) begin
            route_a_r <= reg_wdata & ainp_pkg::MASK_ROUTE_A;
        end
    end

    // (RQ7) shared routing storage, reserved dropped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            route_fifo_r <= ainp_pkg::RST_ROUTE_FIFO;
        end else if (wr_rtf) begin
            route_fifo_r <= reg_wdata & ainp_pkg::MASK_ROUTE_FIFO;
        end
    end

    // (RQ10) polarity storage, both high at reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_ctrl_r <= ainp_pkg::RST_PIN_CTRL;
        end else if (wr_ctl) begin
            pin_ctrl_r <= reg_wdata & ainp_pkg::MASK_PIN_CTRL;
        end
    end

    // Read data captured on read strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 8'h00;
        end else if (ce && reg_rd_en) begin
            reg_rdata_r <= rd_mux;
        end
    end
    assign reg_rdata = reg_rdata_r;

    // ------------------------------------------------------------
    // Motion engine controls
    // ------------------------------------------------------------
    // (RQ2) mode select and (RQ3) axis enables to engine
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_mode_r    <= 1'b0;
            quiet_axis_en_r <= 3'h0;
        end else if (ce) begin
            quiet_mode_r    <= en_group2_r[ainp_pkg::MOTION_SEL_BIT];
            quiet_axis_en_r <= en_group2_r[ainp_pkg::AXIS_Z_BIT:ainp_pkg::AXIS_X_BIT];
        end
    end

    // ------------------------------------------------------------
    // Source vectors
    // ------------------------------------------------------------
    wire logic quiet_active;                                   // Gated quiet event
    wire logic [ainp_pkg::PIN_A_SOURCES-1:0] src_a;            // Pin A sources
    wire logic [ainp_pkg::PIN_A_SOURCES-1:0] mask_a;           // Pin A routing
    wire logic [ainp_pkg::PIN_B_SOURCES-1:0] src_b;            // Pin B sources
    wire logic [ainp_pkg::PIN_B_SOURCES-1:0] mask_b;           // Pin B routing

    // (RQ3) only enabled axes raise the quiet source
    assign quiet_active = |(evt_quiet_axis & en_group2_r[2:0]);
    // (RQ5) (RQ6) motion order matches routing bits 7..0
    assign src_a  = {evt_fifo_full, evt_watermark, evt_data_ready,
                     evt_flat, evt_orientation, evt_single_tap, evt_double_tap,
                     quiet_active, evt_any_motion, evt_high_accel, evt_low_accel};
    // (RQ8) shared bits 2..0 for first pin
    assign mask_a = {route_fifo_r[ainp_pkg::A_FULL_BIT],
                     route_fifo_r[ainp_pkg::A_WATERMARK_BIT],
                     route_fifo_r[ainp_pkg::A_DATA_BIT], route_a_r};
    assign src_b  = {evt_data_ready, evt_watermark, evt_fifo_full};
    // (RQ7) shared bits 7..5 for second pin
    assign mask_b = {route_fifo_r[ainp_pkg::B_DATA_BIT],
                     route_fifo_r[ainp_pkg::B_WATERMARK_BIT],
                     route_fifo_r[ainp_pkg::B_FULL_BIT]};

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // (RQ11) first pin combine
    ainp_pin_drive #(.N(ainp_pkg::PIN_A_SOURCES)) u_pin_a (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .src_active  (src_a),
        .route       (mask_a),
        .active_high (pin_ctrl_r[ainp_pkg::PIN_A_POL_BIT]),
        .pin_r       (first_irq_pin)
    );

    // (RQ11) second pin combine
    ainp_pin_drive #(.N(ainp_pkg::PIN_B_SOURCES)) u_pin_b (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .src_active  (src_b),
        .route       (mask_b),
        .active_high (pin_ctrl_r[ainp_pkg::PIN_B_POL_BIT]),
        .pin_r       (second_irq_pin)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_en2_reserved;
        (en_group2_r[7:4] == 4'h0);
    endproperty
    a_en2_reserved: assert property (p_en2_reserved) else $error("en2 reserved set"); // (RQ1)

    property p_en2_write;
        wr_en2 |=> en_group2_r == ($past(reg_wdata) & 8'h0F);
    endproperty
    a_en2_write: assert property (p_en2_write) else $error("en2 write lost"); // (RQ1)

    property p_mode_follow;
        ce |=> quiet_mode_r == $past(en_group2_r[3]);
    endproperty
    a_mode_follow: assert property (p_mode_follow) else $error("mode select wrong"); // (RQ2)

    property p_axis_gate;
        (ce && evt_quiet_axis != 3'h0 && (evt_quiet_axis & en_group2_r[2:0]) == 3'h0
         && pin_ctrl_r[0] && route_a_r == 8'h08 && route_fifo_r[2:0] == 3'h0)
        |=> !first_irq_pin;
    endproperty
    a_axis_gate: assert property (p_axis_gate) else $error("disabled axis leaked"); // (RQ3)

    property p_route_a_write;
        wr_rta |=> route_a_r == $past(reg_wdata);
    endproperty
    a_route_a_write: assert property (p_route_a_write) else $error("route A write lost"); // (RQ4)

    property p_flat_route;
        (ce && evt_flat && route_a_r[7] && pin_ctrl_r[0]) |=> first_irq_pin;
    endproperty
    a_flat_route: assert property (p_flat_route) else $error("flat not on pin A"); // (RQ5)

    property p_low_route;
        (ce && evt_low_accel && route_a_r[0] && pin_ctrl_r[0]) |=> first_irq_pin;
    endproperty
    a_low_route: assert property (p_low_route) else $error("low-g not on pin A"); // (RQ6)

    property p_b_data;
        (ce && evt_data_ready && route_fifo_r[7] && pin_ctrl_r[2]) |=> second_irq_pin;
    endproperty
    a_b_data: assert property (p_b_data) else $error("data ready not on pin B"); // (RQ7)

    property p_a_full;
        (ce && evt_fifo_full && route_fifo_r[2] && pin_ctrl_r[0]) |=> first_irq_pin;
    endproperty
    a_a_full: assert property (p_a_full) else $error("fifo full not on pin A"); // (RQ8)

    property p_b_idle_low;
        (ce && mask_b == 3'h0 && !pin_ctrl_r[2]) |=> second_irq_pin;
    endproperty
    a_b_idle_low: assert property (p_b_idle_low) else $error("active low idle wrong"); // (RQ10)

    property p_b_quiet;
        (ce && (src_b & mask_b) == 3'h0 && pin_ctrl_r[2]) |=> !second_irq_pin;
    endproperty
    a_b_quiet: assert property (p_b_quiet) else $error("pin B spurious"); // (RQ11)

    c_both_pins: cover property (ce && evt_data_ready ##1 first_irq_pin && second_irq_pin);
    c_no_motion: cover property (wr_en2 ##1 quiet_mode_r == 1'b0 ##1 quiet_mode_r);
    c_low_pol:   cover property (wr_ctl ##1 pin_ctrl_r == 8'h00);
endmodule : ainp_irq_route
`default_nettype wire

// ===== dv/ainp_host_model.sv
// Host side model that drives the register port of the routing block
`timescale 1ns/1ns
`default_nettype none
module ainp_host_model (
    input  wire logic       cmd_wr,    // Host wants a write
    input  wire logic       cmd_rd,    // Host wants a read
    input  wire logic [7:0] cmd_addr,  // Host register offset
    input  wire logic [7:0] cmd_data,  // Host write value
    input  wire logic       raw,       // Skip reserved masking on purpose
    output logic            reg_wr_en, // Write strobe to block
    output logic            reg_rd_en, // Read strobe to block
    output logic      [7:0] reg_addr,  // Offset to block
    output logic      [7:0] reg_wdata  // Write data to block
);
    // ------------------------------------------------------------
    // Reserved bit handling
    // ------------------------------------------------------------
    logic [7:0] keep_mask; // Bits the host may set
    logic [7:0] masked;    // Write value after masking
    assign keep_mask = raw ? 8'hFF :
                       (cmd_addr == ainp_pkg::ADDR_EN_GROUP2)  ? ainp_pkg::MASK_EN_GROUP2 :
                       (cmd_addr == ainp_pkg::ADDR_ROUTE_FIFO) ? ainp_pkg::MASK_ROUTE_FIFO :
                       8'hFF;
    assign masked    = cmd_data & keep_mask;
    // Idle bus lines show the inverse so stale values never look valid
    assign reg_wr_en = cmd_wr;
    assign reg_rd_en = cmd_rd;
    assign reg_wdata = cmd_wr ? masked : ~masked;
    assign reg_addr  = (cmd_wr | cmd_rd) ? cmd_addr : ~cmd_addr;
endmodule : ainp_host_model
`default_nettype wire

// ===== dv/test_accel_int_enable_and_pin_routing.sv
// Self-checking bench for the enable and pin routing block
`timescale 1ns/1ns
`default_nettype none
module test_accel_int_enable_and_pin_routing;
    typedef struct packed { logic [1:0] kind; logic [7:0] exp; } ainp_note_s;
    logic        sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, raw = 1'b0, probe = 1'b0;
    logic        cmd_wr = 1'b0, cmd_rd = 1'b0, rd_seen = 1'b0, pr_seen = 1'b0;
    logic [7:0]  cmd_addr = 8'h00, cmd_data = 8'h00, seen;
    logic [12:0] src = 13'h0000; // flat,orient,stap,dtap,quiet zyx,slope,high,low,full,wm,data
    logic [7:0]  en2 = 8'h00, ra = 8'h00, rf = 8'h00, pc = 8'h05; // Register shadows
    logic        reg_wr_en, reg_rd_en, quiet_mode_r, first_irq_pin, second_irq_pin;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [2:0]  quiet_axis_en_r;
    int          err_count = 0, num_checks = 0, cyc = 0;
    ainp_note_s  notes[$];
    ainp_note_s  cur;
    string       chk_name; // Name of the output under comparison

    always #10 sys_clk = ~sys_clk;

    ainp_host_model ainp_host_model_i (.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .raw(raw), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    ainp_irq_route ainp_irq_route_i (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .evt_flat(src[12]),
        .evt_orientation(src[11]), .evt_single_tap(src[10]), .evt_double_tap(src[9]),
        .evt_quiet_axis(src[8:6]), .evt_any_motion(src[5]), .evt_high_accel(src[4]),
        .evt_low_accel(src[3]), .evt_data_ready(src[0]), .evt_watermark(src[1]),
        .evt_fifo_full(src[2]), .quiet_mode_r(quiet_mode_r),
        .quiet_axis_en_r(quiet_axis_en_r), .first_irq_pin(first_irq_pin),
        .second_irq_pin(second_irq_pin));

    // ------------------------------------------------------------
    // Drivers and expectations
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        cmd_wr = 1'b1;
        cmd_addr = a;
        cmd_data = d;
        @(negedge sys_clk);
        cmd_wr = 1'b0;
        if (ce === 1'b1) begin
            case (a)
                ainp_pkg::ADDR_EN_GROUP2:  en2 = d & ainp_pkg::MASK_EN_GROUP2;
                ainp_pkg::ADDR_ROUTE_A:    ra = d;
                ainp_pkg::ADDR_ROUTE_FIFO: rf = d & ainp_pkg::MASK_ROUTE_FIFO;
                ainp_pkg::ADDR_PIN_CTRL:   pc = d & ainp_pkg::MASK_PIN_CTRL;
                default: ; // Unmapped, nothing stored
            endcase
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        notes.push_back('{2'd0, e});
        @(negedge sys_clk);
        cmd_rd = 1'b1;
        cmd_addr = a;
        @(negedge sys_clk);
        cmd_rd = 1'b0;
    endtask : rd

    task automatic chk(input logic [1:0] k, input logic [7:0] e);
        notes.push_back('{k, e});
        @(negedge sys_clk);
        probe = 1'b1;
        @(negedge sys_clk);
        probe = 1'b0;
        @(negedge sys_clk);
    endtask : chk

    // Expected pin pair {second, first} from shadows and sources
    function automatic logic [7:0] pins_exp();
        logic q;
        logic a;
        logic b;
        q = |(src[8:6] & en2[2:0]);
        a = |(ra & {src[12:9], q, src[5:3]}) | |(rf[2:0] & src[2:0]);
        b = |(rf[7:5] & {src[0], src[1], src[2]});
        return {6'h00, b ^ ~pc[2], a ^ ~pc[0]};
    endfunction : pins_exp

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Output watcher, takes the oldest note per result
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        rd_seen <= reg_rd_en & ce;
        pr_seen <= probe;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            summarize();
        end
    end
    always @(negedge sys_clk) begin
        if (rd_seen || pr_seen) begin
            if (notes.size() == 0) begin
                err_count++;
                $display("ERROR note queue expected a note seen none");
            end else begin
                cur = notes.pop_front();
                seen = (cur.kind == 2'd0) ? reg_rdata :
                       (cur.kind == 2'd1) ? {6'h00, second_irq_pin, first_irq_pin} :
                       {4'h0, quiet_mode_r, quiet_axis_en_r};
                if (cur.kind == 2'd0) chk_name = "reg_rdata";
                else if (cur.kind == 2'd1) chk_name = "irq_pins";
                else chk_name = "quiet_ctrl";
                num_checks++;
                if (seen !== cur.exp) begin
                    err_count++;
                    $display("ERROR %s expected %h seen %h", chk_name, cur.exp, seen);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(82));
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        src = 13'h1FFF;
        rd(ainp_pkg::ADDR_EN_GROUP2, 8'h00);
        rd(ainp_pkg::ADDR_ROUTE_A, 8'h00);
        rd(ainp_pkg::ADDR_ROUTE_FIFO, 8'h00);
        rd(ainp_pkg::ADDR_PIN_CTRL, 8'h05);
        chk(2'd1, 8'h00);
        $display("test reset values done");
        raw = 1'b1;
        wr(ainp_pkg::ADDR_EN_GROUP2, 8'hFF);
        wr(ainp_pkg::ADDR_ROUTE_FIFO, 8'hFF);
        wr(ainp_pkg::ADDR_PIN_CTRL, 8'hFF);
        wr(8'h1B, 8'hFF);
        raw = 1'b0;
        rd(ainp_pkg::ADDR_EN_GROUP2, 8'h0F);
        rd(ainp_pkg::ADDR_ROUTE_FIFO, 8'hE7);
        rd(ainp_pkg::ADDR_PIN_CTRL, 8'h05);
        rd(8'h1B, 8'h00);
        chk(2'd2, 8'h0F);
        wr(ainp_pkg::ADDR_EN_GROUP2, 8'hF5);
        rd(ainp_pkg::ADDR_EN_GROUP2, 8'h05);
        chk(2'd2, 8'h05);
        // Only the quiet source routed, y axis disabled then x enabled
        wr(ainp_pkg::ADDR_ROUTE_FIFO, 8'h00);
        wr(ainp_pkg::ADDR_ROUTE_A, 8'h08);
        src = 13'h0080;
        chk(2'd1, pins_exp());
        src = 13'h0040;
        chk(2'd1, pins_exp());
        $display("test reserved bits done");
        wr(ainp_pkg::ADDR_EN_GROUP2, 8'h07);
        for (int r = 0; r < 16; r++) begin
            wr(ainp_pkg::ADDR_ROUTE_A, (r < 8) ? 8'h01 << r : 8'h00);
            wr(ainp_pkg::ADDR_ROUTE_FIFO, (r >= 8) ? 8'h01 << (r - 8) : 8'h00);
            wr(ainp_pkg::ADDR_PIN_CTRL, r[0] ? 8'h00 : 8'h05);
            for (int j = 0; j < 13; j++) begin
                src = 13'h0001 << j;
                chk(2'd1, pins_exp());
            end
        end
        $display("test walking routes done");
        repeat (40) begin
            wr(ainp_pkg::ADDR_EN_GROUP2, 8'($urandom));
            wr(ainp_pkg::ADDR_ROUTE_A, 8'($urandom));
            wr(ainp_pkg::ADDR_ROUTE_FIFO, 8'($urandom));
            wr(ainp_pkg::ADDR_PIN_CTRL, 8'($urandom));
            src = 13'($urandom);
            chk(2'd1, pins_exp());
            chk(2'd2, {4'h0, en2[3:0]});
            rd(ainp_pkg::ADDR_ROUTE_A, ra);
        end
        $display("test random routing done");
        ce = 1'b0;
        wr(ainp_pkg::ADDR_ROUTE_A, ~ra);
        ce = 1'b1;
        rd(ainp_pkg::ADDR_ROUTE_A, ra);
        $display("test clock enable done");
        repeat (3) @(negedge sys_clk);
        summarize();
    end
endmodule : test_accel_int_enable_and_pin_routing
`default_nettype wire
